// file: common/oscc_pkg.sv
// Shared constants and types of the oscillation settle and CPU clock control.
package oscc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register indices; the byte address is four times the index.
   localparam logic [15:0] IDX_SETTLE = 16'hFFFA;
   localparam logic [15:0] IDX_CPU_CTRL = 16'hFFFB;
   localparam logic [15:0] IDX_STATUS = 16'hFFFC;
   localparam int IDX_W = 16;
   localparam int BYTE_SHIFT = 2;

   ////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [7:0] SETTLE_RESET = 8'h04;
   localparam logic [7:0] CPU_CTRL_RESET = 8'h04;

   ////////////////////////////////////////////////////////////////////////
   // Field positions of the CPU clock control register.
   localparam int MAIN_STOP_BIT = 7;
   localparam int FB_DISABLE_BIT = 6;
   localparam int SRC_STATUS_BIT = 5;
   localparam int SRC_SELECT_BIT = 4;
   localparam int DIV_LSB = 0;
   localparam int DIV_W = 3;

   // Field positions of the settle select register.
   localparam int SETTLE_LSB = 0;
   localparam int SETTLE_W = 3;

   // Field positions of the status register.
   localparam int ST_READY_BIT = 0;
   localparam int ST_SETTLING_BIT = 1;
   localparam int ST_STOPPED_BIT = 2;

   ////////////////////////////////////////////////////////////////////////
   // Settle lengths as powers of two of main-clock cycles, by code.
   localparam int SETTLE_EXP_C0 = 12;
   localparam int SETTLE_EXP_C1 = 14;
   localparam int SETTLE_EXP_C2 = 15;
   localparam int SETTLE_EXP_C3 = 16;
   localparam int SETTLE_EXP_C4 = 17;
   localparam int EXP_W = 5;
   localparam int SETTLE_CNT_W = 18;

   ////////////////////////////////////////////////////////////////////////
   // Clocking figures.
   localparam int MAIN_DIV_MAX_EXP = 4;
   localparam int DIV_CNT_W = 4;
   localparam int SUB_DIVIDE = 2;
   localparam int CPU_CLOCKS_PER_INSTR = 2;

   ////////////////////////////////////////////////////////////////////////
   // Bus encodings.
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;

   typedef enum logic [1:0] {
      OSCC_SETTLE = 2'b00,
      OSCC_RUN = 2'b01,
      OSCC_STOP = 2'b10
   } oscc_state_t;

endpackage : oscc_pkg

// file: rtl/oscc_settle_timer.sv
// Oscillation settle counter that counts running main-clock cycles.
`timescale 1ns/1ps
module oscc_settle_timer #(
   parameter int CNT_W = oscc_pkg::SETTLE_CNT_W,
   parameter logic [4:0] RESET_EXP = 5'(oscc_pkg::SETTLE_EXP_C4)
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic start_i,
   input wire logic [4:0] exp_i,
   input wire logic osc_running_i,
   output logic busy_o,
   output logic done_o
);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [4:0] exp_reg;
   logic [4:0] exp_next;
   logic busy_reg;
   logic busy_next;
   logic done_reg;
   logic done_next;
   logic [CNT_W:0] span;
   logic [CNT_W-1:0] last;

   // The length is latched at start so a rewrite during the wait is harmless.
   always_comb begin
      span = (CNT_W+1)'(1) << exp_reg;
      last = CNT_W'(span - (CNT_W+1)'(1));
      cnt_next = cnt_reg;
      exp_next = exp_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      if (start_i) begin
         cnt_next = '0;
         exp_next = exp_i;
         busy_next = 1'b1;
      end else if (busy_reg && osc_running_i) begin
         if (cnt_reg == last) begin
            busy_next = 1'b0;
            done_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + CNT_W'(1);
         end
      end
   end

   // Reset arms the counter so the wait after reset needs no start pulse.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cnt_reg <= '0;
         exp_reg <= RESET_EXP;
         busy_reg <= 1'b1;
         done_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         exp_reg <= exp_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
      end
   end

   assign busy_o = busy_reg;
   assign done_o = done_reg;

endmodule : oscc_settle_timer

// file: rtl/oscc_cpu_divider.sv
// CPU clock enable divider for the main and subsystem sources.
`timescale 1ns/1ps
module oscc_cpu_divider #(
   parameter int CNT_W = oscc_pkg::DIV_CNT_W
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic main_en_i,
   input wire logic sub_edge_i,
   input wire logic use_sub_i,
   input wire logic [2:0] div_code_i,
   output logic tick_o,
   output logic slot_o
);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic phase_reg;
   logic phase_next;
   logic tick_reg;
   logic tick_next;
   logic slot_reg;
   logic slot_next;
   logic [2:0] exp;
   logic [CNT_W:0] span;
   logic [CNT_W-1:0] limit;
   logic advance;

   always_comb begin
      // Prohibited codes fall back to the slowest main rate.
      exp = (div_code_i > 3'(oscc_pkg::MAIN_DIV_MAX_EXP)) ?
            3'(oscc_pkg::MAIN_DIV_MAX_EXP) : div_code_i;
      span = (CNT_W+1)'(1) << exp;
      if (use_sub_i) begin
         limit = CNT_W'(oscc_pkg::SUB_DIVIDE - 1);
         advance = sub_edge_i;
      end else begin
         limit = CNT_W'(span - (CNT_W+1)'(1));
         advance = main_en_i;
      end
      cnt_next = cnt_reg;
      phase_next = phase_reg;
      tick_next = 1'b0;
      slot_next = 1'b0;
      if (advance) begin
         if (cnt_reg >= limit) begin
            cnt_next = '0;
            tick_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + CNT_W'(1);
         end
      end
      // One instruction slot spans two CPU clocks.
      if (tick_next) begin
         phase_next = ~phase_reg;
         slot_next = phase_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cnt_reg <= '0;
         phase_reg <= 1'b0;
         tick_reg <= 1'b0;
         slot_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         phase_reg <= phase_next;
         tick_reg <= tick_next;
         slot_reg <= slot_next;
      end
   end

   assign tick_o = tick_reg;
   assign slot_o = slot_reg;

endmodule : oscc_cpu_divider

// file: rtl/oscc_top.sv
// Oscillation settle wait and CPU clock control with AHB-Lite registers.
`timescale 1ns/1ps
module oscc_top #(
   parameter int SETTLE_EXP_C0 = oscc_pkg::SETTLE_EXP_C0,
   parameter int SETTLE_EXP_C1 = oscc_pkg::SETTLE_EXP_C1,
   parameter int SETTLE_EXP_C2 = oscc_pkg::SETTLE_EXP_C2,
   parameter int SETTLE_EXP_C3 = oscc_pkg::SETTLE_EXP_C3,
   parameter int SETTLE_EXP_C4 = oscc_pkg::SETTLE_EXP_C4
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   // AHB-Lite slave.
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Core requests.
   input wire logic stop_req_i,
   input wire logic wake_i,
   // Oscillator side.
   input wire logic main_osc_running_i,
   input wire logic sub_osc_in_i,
   output logic main_osc_stop_o,
   output logic main_osc_out_pullup_o,
   output logic sub_feedback_disable_o,
   // CPU clocking.
   output logic cpu_clk_en_o,
   output logic instr_slot_o,
   output logic cpu_ready_o
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic [1:0] run_sync_reg;
   logic [2:0] sub_sync_reg;
   logic osc_running;
   logic sub_edge;

   logic [2:0] settle_reg;
   logic [2:0] settle_next;
   logic [2:0] div_reg;
   logic [2:0] div_next;
   logic sub_sel_reg;
   logic sub_sel_next;
   logic on_sub_reg;
   logic on_sub_next;
   logic mstop_reg;
   logic mstop_next;
   logic fbcut_reg;
   logic fbcut_next;

   logic wr_settle_reg;
   logic wr_settle_next;
   logic wr_ctrl_reg;
   logic wr_ctrl_next;
   logic [31:0] hrdata_reg;
   logic [31:0] hrdata_next;
   logic hreadyout_reg;

   oscc_pkg::oscc_state_t state_reg;
   oscc_pkg::oscc_state_t state_next;
   logic start_reg;
   logic start_next;
   logic [4:0] start_exp_reg;
   logic [4:0] start_exp_next;
   logic stop_reg;
   logic stop_next;
   logic pullup_reg;
   logic pullup_next;
   logic fb_off_reg;
   logic fb_off_next;
   logic ready_reg;
   logic ready_next;

   logic accept;
   logic [29:0] word_addr;
   logic hit_settle;
   logic hit_ctrl;
   logic hit_status;
   logic [7:0] ctrl_view;
   logic [7:0] status_view;
   logic timer_busy;
   logic timer_done;
   logic cpu_tick;
   logic cpu_slot;
   logic main_halted;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers. Only the later stages feed the edge detector.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         run_sync_reg <= 2'h0;
         sub_sync_reg <= 3'h0;
      end else begin
         run_sync_reg <= {run_sync_reg[0], main_osc_running_i};
         sub_sync_reg <= {sub_sync_reg[1:0], sub_osc_in_i};
      end
   end

   assign osc_running = run_sync_reg[1];
   assign sub_edge = sub_sync_reg[1] & ~sub_sync_reg[2];

   ////////////////////////////////////////////////////////////////////////
   // Bus decode. The data phase never stalls, so hready only gates accept.
   always_comb begin
      word_addr = haddr_i[31:oscc_pkg::BYTE_SHIFT];
      accept = hsel_i && hready_i && htrans_i[1];
      hit_settle = (word_addr == 30'(oscc_pkg::IDX_SETTLE));
      hit_ctrl = (word_addr == 30'(oscc_pkg::IDX_CPU_CTRL));
      hit_status = (word_addr == 30'(oscc_pkg::IDX_STATUS));
      wr_settle_next = accept && hwrite_i && hit_settle;
      wr_ctrl_next = accept && hwrite_i && hit_ctrl;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file. Writes land in the data phase from the low byte.
   always_comb begin
      settle_next = settle_reg;
      div_next = div_reg;
      sub_sel_next = sub_sel_reg;
      mstop_next = mstop_reg;
      fbcut_next = fbcut_reg;
      on_sub_next = on_sub_reg;
      // Byte lanes are not checked: the register is only ever written whole.
      if (wr_settle_reg) begin
         settle_next = hwdata_i[oscc_pkg::SETTLE_LSB +: oscc_pkg::SETTLE_W];
      end
      if (wr_ctrl_reg) begin
         div_next = hwdata_i[oscc_pkg::DIV_LSB +: oscc_pkg::DIV_W];
         sub_sel_next = hwdata_i[oscc_pkg::SRC_SELECT_BIT];
         mstop_next = hwdata_i[oscc_pkg::MAIN_STOP_BIT];
         fbcut_next = hwdata_i[oscc_pkg::FB_DISABLE_BIT];
      end
      // The source switch takes effect on a CPU clock boundary, and never
      // onto a main clock that software has stopped.
      if (cpu_tick && (sub_sel_reg || !mstop_reg)) begin
         on_sub_next = sub_sel_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         settle_reg <= oscc_pkg::SETTLE_RESET[2:0];
         div_reg <= oscc_pkg::CPU_CTRL_RESET[2:0];
         sub_sel_reg <= oscc_pkg::CPU_CTRL_RESET[oscc_pkg::SRC_SELECT_BIT];
         mstop_reg <= oscc_pkg::CPU_CTRL_RESET[oscc_pkg::MAIN_STOP_BIT];
         fbcut_reg <= oscc_pkg::CPU_CTRL_RESET[oscc_pkg::FB_DISABLE_BIT];
         on_sub_reg <= oscc_pkg::CPU_CTRL_RESET[oscc_pkg::SRC_STATUS_BIT];
         wr_settle_reg <= 1'b0;
         wr_ctrl_reg <= 1'b0;
      end else begin
         settle_reg <= settle_next;
         div_reg <= div_next;
         sub_sel_reg <= sub_sel_next;
         mstop_reg <= mstop_next;
         fbcut_reg <= fbcut_next;
         on_sub_reg <= on_sub_next;
         wr_settle_reg <= wr_settle_next;
         wr_ctrl_reg <= wr_ctrl_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data. The settle and control views use the next values so that a read right after
   // a write to the same register sees the new contents.
   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[oscc_pkg::MAIN_STOP_BIT] = mstop_next;
      ctrl_view[oscc_pkg::FB_DISABLE_BIT] = fbcut_next;
      ctrl_view[oscc_pkg::SRC_STATUS_BIT] = on_sub_next;
      ctrl_view[oscc_pkg::SRC_SELECT_BIT] = sub_sel_next;
      ctrl_view[oscc_pkg::DIV_LSB +: oscc_pkg::DIV_W] = div_next;
      status_view = 8'h00;
      status_view[oscc_pkg::ST_READY_BIT] = ready_reg;
      status_view[oscc_pkg::ST_SETTLING_BIT] = timer_busy;
      status_view[oscc_pkg::ST_STOPPED_BIT] = stop_reg;
      hrdata_next = hrdata_reg;
      if (accept && !hwrite_i) begin
         hrdata_next = 32'h0000_0000;
         if (hit_settle) begin
            hrdata_next = {29'h0, settle_next};
         end else if (hit_ctrl) begin
            hrdata_next = {24'h0, ctrl_view};
         end else if (hit_status) begin
            hrdata_next = {24'h0, status_view};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         hrdata_reg <= 32'h0000_0000;
         hreadyout_reg <= 1'b1;
      end else begin
         hrdata_reg <= hrdata_next;
         hreadyout_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operating state and oscillator controls.
   always_comb begin
      state_next = state_reg;
      start_next = 1'b0;
      start_exp_next = start_exp_reg;
      // Settle length by code; prohibited codes use the longest wait.
      case (settle_reg)
         3'h0: start_exp_next = 5'(SETTLE_EXP_C0);
         3'h1: start_exp_next = 5'(SETTLE_EXP_C1);
         3'h2: start_exp_next = 5'(SETTLE_EXP_C2);
         3'h3: start_exp_next = 5'(SETTLE_EXP_C3);
         default: start_exp_next = 5'(SETTLE_EXP_C4);
      endcase
      case (state_reg)
         oscc_pkg::OSCC_SETTLE: begin
            if (timer_done) begin
               state_next = oscc_pkg::OSCC_RUN;
            end
         end
         oscc_pkg::OSCC_RUN: begin
            // STOP is refused while running on the subsystem clock.
            if (stop_req_i && !on_sub_reg) begin
               state_next = oscc_pkg::OSCC_STOP;
            end
         end
         oscc_pkg::OSCC_STOP: begin
            if (wake_i) begin
               state_next = oscc_pkg::OSCC_SETTLE;
               start_next = 1'b1;
            end
         end
         default: begin
            state_next = oscc_pkg::OSCC_SETTLE;
            start_next = 1'b1;
         end
      endcase
      // The stop bit only bites once the CPU has left the main clock.
      main_halted = (state_next == oscc_pkg::OSCC_STOP) ||
                    (mstop_next && on_sub_next);
      stop_next = main_halted;
      // An external main clock would fight this pull-up.
      pullup_next = main_halted;
      fb_off_next = fbcut_next;
      ready_next = (state_next == oscc_pkg::OSCC_RUN);
   end

   // The main oscillator is held stopped while reset is low.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state_reg <= oscc_pkg::OSCC_SETTLE;
         start_reg <= 1'b0;
         start_exp_reg <= 5'(oscc_pkg::SETTLE_EXP_C4);
         stop_reg <= 1'b1;
         pullup_reg <= 1'b0;
         fb_off_reg <= 1'b0;
         ready_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         start_reg <= start_next;
         start_exp_reg <= start_exp_next;
         stop_reg <= stop_next;
         pullup_reg <= pullup_next;
         fb_off_reg <= fb_off_next;
         ready_reg <= ready_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Settle counter and CPU clock divider.
   oscc_settle_timer #(
      .CNT_W(oscc_pkg::SETTLE_CNT_W),
      .RESET_EXP(5'(SETTLE_EXP_C4))
   ) u_settle (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .start_i(start_reg),
      .exp_i(start_exp_reg),
      .osc_running_i(osc_running),
      .busy_o(timer_busy),
      .done_o(timer_done)
   );

   // The CPU clock runs only in RUN, and the main path only while unhalted.
   oscc_cpu_divider #(
      .CNT_W(oscc_pkg::DIV_CNT_W)
   ) u_div (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .main_en_i(ready_reg && !stop_reg),
      .sub_edge_i(ready_reg && sub_edge),
      .use_sub_i(on_sub_reg),
      .div_code_i(div_reg),
      .tick_o(cpu_tick),
      .slot_o(cpu_slot)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign hrdata_o = hrdata_reg;
   assign hreadyout_o = hreadyout_reg;
   assign hresp_o = 1'b0;
   assign main_osc_stop_o = stop_reg;
   assign main_osc_out_pullup_o = pullup_reg;
   assign sub_feedback_disable_o = fb_off_reg;
   assign cpu_clk_en_o = cpu_tick;
   assign instr_slot_o = cpu_slot;
   assign cpu_ready_o = ready_reg;

endmodule : oscc_top

// file: test/oscc_top_assertions.sv
// Concurrent checks on the ports of the oscillation settle clock control.
`timescale 1ns/1ps
module oscc_top_checker #(
   parameter int SETTLE_EXP_C0 = 12,
   parameter int SETTLE_EXP_C4 = 17
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic stop_req_i,
   input wire logic wake_i,
   input wire logic main_osc_running_i,
   input wire logic main_osc_stop_o,
   input wire logic main_osc_out_pullup_o,
   input wire logic cpu_clk_en_o,
   input wire logic instr_slot_o,
   input wire logic cpu_ready_o
);
   localparam logic [31:0] A_SET =
      32'(oscc_pkg::IDX_SETTLE) << oscc_pkg::BYTE_SHIFT;
   logic [19:0] run_cnt;
   logic rd_settle;
   ////////////////////////////////////////////////////////////////////////
   // Raw running cycles while the CPU is held; the synchroniser lag makes
   // this a little larger than the design's own count, never smaller.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || cpu_ready_o) begin
         run_cnt <= '0;
      end else if (main_osc_running_i) begin
         run_cnt <= run_cnt + 20'h1;
      end
   end
   always_ff @(posedge clk_i) begin
      rd_settle <= rst_b_i && hsel_i && hready_i && htrans_i[1] &&
         !hwrite_i && (haddr_i == A_SET);
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   a_reset_release: assert property (
      $rose(rst_b_i) |-> main_osc_stop_o && !cpu_ready_o ##1 !main_osc_stop_o)
      else $error("oscillator not restarted after reset");
   a_pullup_with_stop: assert property (
      main_osc_out_pullup_o |-> main_osc_stop_o)
      else $error("output pin pulled up while oscillator runs");
   a_stop_entry: assert property (
      $fell(cpu_ready_o) |-> main_osc_stop_o && main_osc_out_pullup_o)
      else $error("STOP entered without halting the oscillator");
   a_wake_restart: assert property (
      !cpu_ready_o && main_osc_out_pullup_o && wake_i |=> !main_osc_stop_o)
      else $error("wake did not restart the oscillator");
   a_no_clk_held: assert property (
      !cpu_ready_o && !$past(cpu_ready_o) |-> !cpu_clk_en_o)
      else $error("CPU clock ran while held");
   a_slot_on_tick: assert property (
      instr_slot_o |-> cpu_clk_en_o)
      else $error("instruction slot without CPU clock");
   a_settle_min: assert property (
      $rose(cpu_ready_o) |-> run_cnt >= (20'h1 << SETTLE_EXP_C0))
      else $error("CPU released before the shortest settle wait");
   a_settle_max: assert property (
      run_cnt <= (20'h1 << SETTLE_EXP_C4) + 20'h8)
      else $error("settle wait longer than the longest code");
   a_settle_high_zero: assert property (
      rd_settle |-> hrdata_o[31:3] == '0)
      else $error("settle select upper bits not zero");
endmodule : oscc_top_checker

bind oscc_top oscc_top_checker #(.SETTLE_EXP_C0(SETTLE_EXP_C0),
   .SETTLE_EXP_C4(SETTLE_EXP_C4)) u_oscc_top_checker (.clk_i(clk_i),
   .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
   .hrdata_o(hrdata_o), .stop_req_i(stop_req_i), .wake_i(wake_i),
   .main_osc_running_i(main_osc_running_i),
   .main_osc_stop_o(main_osc_stop_o),
   .main_osc_out_pullup_o(main_osc_out_pullup_o),
   .cpu_clk_en_o(cpu_clk_en_o), .instr_slot_o(instr_slot_o),
   .cpu_ready_o(cpu_ready_o));

// file: test/oscc_osc_model.sv
// Behavioural main resonator and subsystem crystal for the bench.
`timescale 1ns/1ps
module oscc_osc_model #(
   parameter int START_DLY = 5,
   parameter int SUB_HALF = 8
) (
   input wire logic clk_i,
   input wire logic main_osc_stop_i,
   input wire logic fb_disable_i,
   output logic main_osc_running_o,
   output logic sub_osc_o
);
   int start_cnt = 0;
   int sub_cnt = 0;
   initial begin
      main_osc_running_o = 1'b0;
      sub_osc_o = 1'b0;
   end
   // A resonator, not an external clock, so halting it is legal.
   // Oscillation builds up only some cycles after the halt is lifted,
   // so a design that counts the start-up delay finishes early.
   always @(posedge clk_i) begin
      if (main_osc_stop_i !== 1'b0) begin
         start_cnt <= 0;
         main_osc_running_o <= 1'b0;
      end else if (start_cnt < START_DLY) begin
         start_cnt <= start_cnt + 1;
      end else begin
         main_osc_running_o <= 1'b1;
      end
   end
   // Without its feedback resistor the crystal stops swinging.
   always @(posedge clk_i) begin
      if (sub_cnt == SUB_HALF - 1) begin
         sub_cnt <= 0;
         if (fb_disable_i !== 1'b1) sub_osc_o <= !sub_osc_o;
      end else begin
         sub_cnt <= sub_cnt + 1;
      end
   end
endmodule : oscc_osc_model

// file: test/test_oscc_top.sv
// Self-checking bench for the oscillation settle and CPU clock control.
`timescale 1ns/1ps
module test_oscc_top;
   localparam int EXPS [5] = '{2, 3, 4, 5, 6};
   localparam int SUB_HALF = 8;
   localparam logic [31:0] A_SET =
      32'(oscc_pkg::IDX_SETTLE) << oscc_pkg::BYTE_SHIFT;
   localparam logic [31:0] A_CTL =
      32'(oscc_pkg::IDX_CPU_CTRL) << oscc_pkg::BYTE_SHIFT;
   localparam logic [31:0] A_STA =
      32'(oscc_pkg::IDX_STATUS) << oscc_pkg::BYTE_SHIFT;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic hsel_i = 1'b0;
   logic hwrite_i = 1'b0;
   logic stop_req_i = 1'b0;
   logic wake_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [31:0] hwdata_i = 32'h0;
   logic [1:0] htrans_i = 2'h0;
   logic [2:0] hsize_i = 3'h2;
   logic [31:0] hrdata_o;
   logic hreadyout_o, hresp_o, main_osc_running_i, sub_osc_in_i;
   logic main_osc_stop_o, main_osc_out_pullup_o, sub_feedback_disable_o;
   logic cpu_clk_en_o, instr_slot_o, cpu_ready_o;
   int bad_count = 0;
   int checks = 0;

   oscc_top #(.SETTLE_EXP_C0(EXPS[0]), .SETTLE_EXP_C1(EXPS[1]),
      .SETTLE_EXP_C2(EXPS[2]), .SETTLE_EXP_C3(EXPS[3]),
      .SETTLE_EXP_C4(EXPS[4])) u_oscc_top (.clk_i(clk_i),
      .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
      .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .stop_req_i(stop_req_i), .wake_i(wake_i),
      .main_osc_running_i(main_osc_running_i),
      .sub_osc_in_i(sub_osc_in_i), .main_osc_stop_o(main_osc_stop_o),
      .main_osc_out_pullup_o(main_osc_out_pullup_o),
      .sub_feedback_disable_o(sub_feedback_disable_o),
      .cpu_clk_en_o(cpu_clk_en_o), .instr_slot_o(instr_slot_o),
      .cpu_ready_o(cpu_ready_o));

   oscc_osc_model #(.START_DLY(5), .SUB_HALF(SUB_HALF)) u_oscc_osc_model (
      .clk_i(clk_i), .main_osc_stop_i(main_osc_stop_o),
      .fb_disable_i(sub_feedback_disable_o),
      .main_osc_running_o(main_osc_running_i), .sub_osc_o(sub_osc_in_i));

   initial begin
      forever #5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic int div_of(input int c);
      return (c <= 4) ? (1 << c) : (1 << oscc_pkg::MAIN_DIV_MAX_EXP);
   endfunction : div_of
   function automatic int wait_of(input int c);
      return 1 << ((c < 5) ? EXPS[c] : EXPS[4]);
   endfunction : wait_of
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   task automatic check_range(input int got, input int lo, input int hi);
      checks++;
      if (got < lo || got > hi) begin
         bad_count++;
         $display("Error at %0t: got %0h expected %0h to %0h", $time, got,
            lo, hi);
      end
   endtask : check_range
   task automatic bus(input logic wr, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      haddr_i <= a;
      htrans_i <= oscc_pkg::HTRANS_NONSEQ;
      hwrite_i <= wr;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hsel_i <= 1'b0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      q = hrdata_o;
   endtask : bus
   task automatic wait_ready(output int n);
      n = 0;
      while (cpu_ready_o !== 1'b1 && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
   endtask : wait_ready
   task automatic gaps(output int ge, output int gs);
      int e[$];
      int s[$];
      for (int t = 0; t < 400; t++) begin
         @(posedge clk_i);
         if (cpu_clk_en_o === 1'b1) e.push_back(t);
         if (instr_slot_o === 1'b1) s.push_back(t);
      end
      ge = (e.size() > 3) ? e[3] - e[2] : 0;
      gs = (s.size() > 2) ? s[2] - s[1] : 0;
   endtask : gaps
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (30000) @(posedge clk_i);
      bad_count++;
      close_out();
   end
   initial begin
      int n, ge, gs;
      logic [31:0] q, r;
      void'($urandom(32'hEF6C));
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      wait_ready(n);
      check_range(n, wait_of(4) + 5, wait_of(4) + 20);
      bus(1'b0, A_SET, 32'h0, q);
      check(q, 32'h04);
      bus(1'b0, A_CTL, 32'h0, q);
      check(q, 32'h04);
      bus(1'b0, A_STA, 32'h0, q);
      check({31'h0, q[oscc_pkg::ST_READY_BIT]}, 32'h1);
      bus(1'b0, 32'h100, 32'h0, q);
      check(q, 32'h0);
      // Random words with junk upper bits; only the code field may stick.
      for (int i = 0; i < 6; i++) begin
         r = $urandom();
         bus(1'b1, A_SET, r, q);
         bus(1'b0, A_SET, 32'h0, q);
         check(q, {29'h0, r[2:0]});
      end
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, A_CTL, 32'(c), q);
         gaps(ge, gs);
         check_range(ge, div_of(c), div_of(c));
         check_range(gs, 2 * div_of(c), 2 * div_of(c));
      end
      for (int c = 0; c < 6; c++) begin
         bus(1'b1, A_SET, 32'(c), q);
         @(posedge clk_i);
         stop_req_i <= 1'b1;
         @(posedge clk_i);
         stop_req_i <= 1'b0;
         @(posedge clk_i);
         check({30'h0, main_osc_stop_o, main_osc_out_pullup_o}, 32'h3);
         check({31'h0, cpu_ready_o}, 32'h0);
         repeat (4) @(posedge clk_i);
         wake_i <= 1'b1;
         @(posedge clk_i);
         wake_i <= 1'b0;
         wait_ready(n);
         check_range(n, wait_of(c) + 5, wait_of(c) + 20);
      end
      // Stop bit and feedback cut while still on the main clock.
      bus(1'b1, A_CTL, 32'hC0, q);
      repeat (4) @(posedge clk_i);
      check({31'h0, main_osc_stop_o}, 32'h0);
      check({31'h0, sub_feedback_disable_o}, 32'h1);
      bus(1'b1, A_CTL, 32'h90, q);
      n = 0;
      q = 32'h0;
      while (q[oscc_pkg::SRC_STATUS_BIT] !== 1'b1 && n < 50) begin
         bus(1'b0, A_CTL, 32'h0, q);
         n++;
      end
      check(q, 32'hB0);
      stop_req_i <= 1'b1;
      @(posedge clk_i);
      stop_req_i <= 1'b0;
      @(posedge clk_i);
      check({31'h0, cpu_ready_o}, 32'h1);
      repeat (4) @(posedge clk_i);
      check({30'h0, main_osc_stop_o, main_osc_out_pullup_o}, 32'h3);
      gaps(ge, gs);
      check_range(ge, 4 * SUB_HALF, 4 * SUB_HALF);
      check_range(gs, 8 * SUB_HALF, 8 * SUB_HALF);
      close_out();
   end
endmodule : test_oscc_top
